// ===== design/lcdsc_map.vh
// Constants for the segment/common LCD driver core: levels, counts and register map.
`ifndef LCDSC_MAP_VH
`define LCDSC_MAP_VH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define LCDSC_OUTPUTS 160
`define LCDSC_HALF 80
`define LCDSC_WORDS_PER_LINE 5'h14

// ----------------------------------------------------------------------------
// Drive level codes, two bits per driver output
// ----------------------------------------------------------------------------
`define LCDSC_LVL_BOTTOM 2'h0
`define LCDSC_LVL_LOWER 2'h1
`define LCDSC_LVL_UPPER 2'h2
`define LCDSC_LVL_TOP 2'h3

// ----------------------------------------------------------------------------
// Register map (byte addresses) and fields
// ----------------------------------------------------------------------------
`define LCDSC_ADDR_CTRL 8'h00
`define LCDSC_ADDR_STATUS 8'h04
`define LCDSC_CTRL_RESET 32'h00000000
`define LCDSC_CTRL_SOFT_BLANK 0
`define LCDSC_ST_WORDS_LSB 0
`define LCDSC_ST_SELECTED 8
`define LCDSC_ST_ARMED 9
`define LCDSC_ST_DESELECT 10
`define LCDSC_ST_SEGMENT 11
`define LCDSC_ST_CASC_LOW 12

`endif

// ===== design/lcdsc_core.v
// Digital core of a 160-output segment/common LCD driver with an APB register slave.
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "lcdsc_map.vh"

module lcdsc_core
(
    // Clock and reset.
    input wire CLOCK,
    input wire RST_N,
    // APB register slave.
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    // Controller pins, all asynchronous to CLOCK.
    input wire PIXEL_SHIFT_CLOCK,
    input wire LINE_LATCH_PULSE,
    input wire WIDTH_OR_DUAL_SELECT,
    input wire SHIFT_DIR_SELECT,
    input wire SEGMENT_MODE_SELECT,
    input wire OUTPUT_BLANK_N,
    input wire FRAME_POLARITY,
    input wire [7:0] DISPLAY_DATA_IN,
    // Cascade port A, two-way pin split in three.
    input wire CASCADE_PORT_A_IN,
    output reg CASCADE_PORT_A_OUT,
    output reg CASCADE_PORT_A_OE_N,
    // Cascade port B, two-way pin split in three.
    input wire CASCADE_PORT_B_IN,
    output reg CASCADE_PORT_B_OUT,
    output reg CASCADE_PORT_B_OE_N,
    // Internal pull-down enables for the pad ring.
    output reg CASCADE_PORT_A_PULLDOWN,
    output reg CASCADE_PORT_B_PULLDOWN,
    output reg DUAL_CHAIN_PULLDOWN,
    output reg PIXEL_CLOCK_PULLDOWN,
    // Level code per output: output k uses bits [2k+1:2k].
    output reg [319:0] DRIVER_OUTPUTS
);

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------

    // Pin bundle: 0 pixel clk, 1 pulse, 2 width, 3 dir, 4 seg, 5 blank_n,
    // 6 polarity, 7 casc A, 8 casc B, 16:9 data.
    wire [16:0] pins_raw;
    reg [16:0] pins_meta_ff; // First stage, read only by the second stage.
    reg [16:0] pins_ff; // Second stage, safe to use.
    reg pix_prev_ff; // Pixel clock one cycle ago, for edge finding.
    reg lp_prev_ff; // Line pulse one cycle ago, for edge finding.

    assign pins_raw = {DISPLAY_DATA_IN, CASCADE_PORT_B_IN, CASCADE_PORT_A_IN,
                       FRAME_POLARITY, OUTPUT_BLANK_N, SEGMENT_MODE_SELECT,
                       SHIFT_DIR_SELECT, WIDTH_OR_DUAL_SELECT, LINE_LATCH_PULSE,
                       PIXEL_SHIFT_CLOCK};

    // Two flops on every pin; pin levels are meaningless until they settle.
    always @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            pins_meta_ff <= 17'h00000;
            pins_ff <= 17'h00000;
            pix_prev_ff <= 1'b0;
            lp_prev_ff <= 1'b0;
        end
        else
        begin
            pins_meta_ff <= pins_raw;
            pins_ff <= pins_meta_ff;
            pix_prev_ff <= pins_ff[0];
            lp_prev_ff <= pins_ff[1];
        end
    end

    wire pix_s = pins_ff[0]; // Pixel shift clock, synchronised.
    wire lp_s = pins_ff[1]; // Line latch pulse, synchronised.
    wire wide_s = pins_ff[2]; // Width select or dual select.
    wire dir_s = pins_ff[3]; // Shift direction select.
    wire seg_s = pins_ff[4]; // High selects segment mode.
    wire blank_pin_n = pins_ff[5]; // Blanking pin, active low.
    wire fr_s = pins_ff[6]; // Frame polarity.
    wire casc_a_s = pins_ff[7]; // Cascade port A as seen on the pin.
    wire casc_b_s = pins_ff[8]; // Cascade port B as seen on the pin.
    wire [7:0] data_s = pins_ff[16:9]; // Display data.

    // Falling edges; the link clock runs far below CLOCK, so none are missed.
    wire pix_fall = pix_prev_ff & ~pix_s;
    wire lp_fall = lp_prev_ff & ~lp_s;

    // ------------------------------------------------------------------------
    // Register slave
    // ------------------------------------------------------------------------

    reg [31:0] ctrl_ff; // Control register; bit 0 adds a software blank.
    wire addr_ok = (PADDR == `LCDSC_ADDR_CTRL) || (PADDR == `LCDSC_ADDR_STATUS);
    wire [31:0] status_word;

    // Zero wait states: every access completes in its first access cycle.
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~addr_ok;

    // Writes land at the access edge; read data is loaded in the setup cycle.
    always @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            ctrl_ff <= `LCDSC_CTRL_RESET;
            PRDATA <= 32'h00000000;
        end
        else
        begin
            if (PSEL && PENABLE && PWRITE && (PADDR == `LCDSC_ADDR_CTRL))
            begin
                // Only bit 0 is implemented; the rest read as zero.
                ctrl_ff <= {31'h00000000, PWDATA[0]};
            end
            if (PSEL && !PENABLE && !PWRITE)
            begin
                // Unmapped addresses read as zero.
                if (PADDR == `LCDSC_ADDR_CTRL)
                    PRDATA <= ctrl_ff;
                else if (PADDR == `LCDSC_ADDR_STATUS)
                    PRDATA <= status_word;
                else
                    PRDATA <= 32'h00000000;
            end
        end
    end

    // Effective blank: pin low or the software override set.
    wire blank_n = blank_pin_n & ~ctrl_ff[`LCDSC_CTRL_SOFT_BLANK];

    // ------------------------------------------------------------------------
    // Segment capture control
    // ------------------------------------------------------------------------

    reg armed_ff; // Waiting for the upstream cascade select.
    reg selected_ff; // Capturing data.
    reg [4:0] word_cnt_ff; // Whole 8-bit words taken this line.
    reg half_ff; // First nibble held, second still due.
    reg [3:0] nib_ff; // First nibble of a 4-bit word pair.
    reg casc_low_ff; // Cascade output held low.
    reg [159:0] data_latch_ff; // Captured line, not yet shown.
    reg [159:0] line_ff; // Line latch in segment mode, shift chain in common.
    reg deselect_ff; // Blanking released, no pulse seen yet.

    // Upstream select arrives on B when direction is low, on A when high.
    wire casc_in = dir_s ? casc_a_s : casc_b_s;
    wire take = seg_s & selected_ff & pix_fall;
    wire [7:0] word = wide_s ? data_s : {nib_ff, data_s[3:0]};
    wire word_done = take & (wide_s | half_ff);
    wire [7:0] bit_base = {word_cnt_ff, 3'h0};

    // Select, count and cascade handshake.
    always @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            armed_ff <= 1'b0;
            selected_ff <= 1'b0;
            word_cnt_ff <= 5'h00;
            half_ff <= 1'b0;
            nib_ff <= 4'h0;
            casc_low_ff <= 1'b0;
        end
        else if (!seg_s)
        begin
            // Common mode leaves the segment capture idle.
            armed_ff <= 1'b0;
            selected_ff <= 1'b0;
            word_cnt_ff <= 5'h00;
            half_ff <= 1'b0;
            casc_low_ff <= 1'b0;
        end
        else if (lp_fall)
        begin
            // A line pulse restarts capture and waits for a select.
            armed_ff <= 1'b1;
            selected_ff <= 1'b0;
            word_cnt_ff <= 5'h00;
            half_ff <= 1'b0;
            casc_low_ff <= 1'b0;
        end
        else
        begin
            if (armed_ff && !casc_in)
            begin
                // Upstream hands over: start taking data.
                armed_ff <= 1'b0;
                selected_ff <= 1'b1;
            end
            if (take && !wide_s && !half_ff)
            begin
                // First of two clocks in 4-bit mode.
                nib_ff <= data_s[3:0];
                half_ff <= 1'b1;
            end
            if (word_done)
            begin
                half_ff <= 1'b0;
                word_cnt_ff <= word_cnt_ff + 5'h01;
                if (word_cnt_ff == `LCDSC_WORDS_PER_LINE - 5'h01)
                begin
                    // 160 bits in: deselect, pass the select on.
                    selected_ff <= 1'b0;
                    casc_low_ff <= 1'b1;
                end
            end
            if (casc_low_ff && pix_fall)
            begin
                // Low from one pixel-clock fall to the next.
                casc_low_ff <= 1'b0;
            end
        end
    end

    // Words go into the data latch; blanking does not stop this.
    integer i;
    always @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            data_latch_ff <= 160'h0;
        end
        else if (word_done)
        begin
            for (i = 0; i < 8; i = i + 1)
            begin
                // Low fills from the top end, high from output 1.
                if (dir_s)
                    data_latch_ff[bit_base + 8'h07 - i[7:0]] <= word[i];
                else
                    data_latch_ff[8'h98 - bit_base + i[7:0]] <= word[i];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Line latch and common shift chain
    // ------------------------------------------------------------------------

    wire dual = ~seg_s & wide_s;
    wire d7_in = data_s[7]; // Second chain feed in dual mode.
    wire chain_in = dir_s ? casc_a_s : casc_b_s;

    // One register serves as line latch or as shift chain.
    always @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            line_ff <= 160'h0;
            deselect_ff <= 1'b0;
        end
        else if (!blank_n)
        begin
            // Blanking clears the latch and arms the deselect phase.
            line_ff <= 160'h0;
            deselect_ff <= 1'b1;
        end
        else if (lp_fall)
        begin
            deselect_ff <= 1'b0;
            if (seg_s)
                line_ff <= data_latch_ff;
            else if (!dir_s)
            begin
                // Toward output 1; dual splits at 80/81.
                line_ff <= {chain_in, line_ff[159:1]};
                if (dual)
                    line_ff[79] <= d7_in;
            end
            else
            begin
                // Toward output 160.
                line_ff <= {line_ff[158:0], chain_in};
                if (dual)
                    line_ff[80] <= d7_in;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Pins: cascade ports and pull-downs
    // ------------------------------------------------------------------------

    // Segment: idle high, low pulse at end. Common: chain end bit.
    wire casc_drive = seg_s ? ~casc_low_ff : (dir_s ? line_ff[159] : line_ff[0]);

    // Registered so that pin levels never glitch on mode changes.
    always @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            CASCADE_PORT_A_OUT <= 1'b1;
            CASCADE_PORT_A_OE_N <= 1'b1;
            CASCADE_PORT_B_OUT <= 1'b1;
            CASCADE_PORT_B_OE_N <= 1'b1;
            CASCADE_PORT_A_PULLDOWN <= 1'b0;
            CASCADE_PORT_B_PULLDOWN <= 1'b0;
            DUAL_CHAIN_PULLDOWN <= 1'b0;
            PIXEL_CLOCK_PULLDOWN <= 1'b0;
        end
        else
        begin
            // Direction low: A drives, B listens; high swaps.
            CASCADE_PORT_A_OUT <= casc_drive;
            CASCADE_PORT_A_OE_N <= dir_s;
            CASCADE_PORT_B_OUT <= casc_drive;
            CASCADE_PORT_B_OE_N <= ~dir_s;
            // Pull-downs only on common-mode inputs.
            CASCADE_PORT_A_PULLDOWN <= ~seg_s & dir_s;
            CASCADE_PORT_B_PULLDOWN <= ~seg_s & ~dir_s;
            DUAL_CHAIN_PULLDOWN <= dual;
            PIXEL_CLOCK_PULLDOWN <= ~seg_s;
        end
    end

    // ------------------------------------------------------------------------
    // Four-level output selection
    // ------------------------------------------------------------------------

    // Level when neither blanked nor in the deselect phase.
    function [1:0] pick_level;
        input seg;
        input fr;
        input b;
        begin
            if (seg)
                pick_level = fr ? (b ? `LCDSC_LVL_TOP : `LCDSC_LVL_UPPER)
                                : (b ? `LCDSC_LVL_BOTTOM : `LCDSC_LVL_LOWER);
            else
                pick_level = fr ? (b ? `LCDSC_LVL_BOTTOM : `LCDSC_LVL_LOWER)
                                : (b ? `LCDSC_LVL_TOP : `LCDSC_LVL_UPPER);
        end
    endfunction

    // Deselect level follows frame polarity like an unlit pixel.
    wire [1:0] desel_lvl = seg_s ? (fr_s ? `LCDSC_LVL_UPPER : `LCDSC_LVL_LOWER)
                                 : (fr_s ? `LCDSC_LVL_LOWER : `LCDSC_LVL_UPPER);

    // One level per output, each tied to its own latch bit.
    genvar g;
    generate
        for (g = 0; g < `LCDSC_OUTPUTS; g = g + 1)
        begin : g_out
            always @(posedge CLOCK)
            begin
                if (!RST_N)
                    DRIVER_OUTPUTS[2*g+1:2*g] <= `LCDSC_LVL_BOTTOM;
                else if (!blank_n)
                    DRIVER_OUTPUTS[2*g+1:2*g] <= `LCDSC_LVL_BOTTOM;
                else if (deselect_ff)
                    DRIVER_OUTPUTS[2*g+1:2*g] <= desel_lvl;
                else
                    DRIVER_OUTPUTS[2*g+1:2*g] <= pick_level(seg_s, fr_s, line_ff[g]);
            end
        end
    endgenerate

    // Status shows the capture engine's state, the deselect phase and the segment mode pin.
    assign status_word = {19'h00000, casc_low_ff, seg_s, deselect_ff, armed_ff,
                          selected_ff, 3'h0, word_cnt_ff};

endmodule

// ===== test/lcdsc_core_assertions.sv
// Port checker for the segment/common driver core.
`timescale 1ns/1ps
module lcdsc_core_assertions
(
    // Clock and reset.
    input wire CLOCK,
    input wire RST_N,
    // Register bus.
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [31:0] PRDATA,
    input wire PREADY,
    input wire PSLVERR,
    // Controller pins.
    input wire WIDTH_OR_DUAL_SELECT,
    input wire SHIFT_DIR_SELECT,
    input wire SEGMENT_MODE_SELECT,
    input wire OUTPUT_BLANK_N,
    // Pad controls and outputs.
    input wire CASCADE_PORT_A_OE_N,
    input wire CASCADE_PORT_B_OE_N,
    input wire CASCADE_PORT_A_PULLDOWN,
    input wire CASCADE_PORT_B_PULLDOWN,
    input wire DUAL_CHAIN_PULLDOWN,
    input wire PIXEL_CLOCK_PULLDOWN,
    input wire [319:0] DRIVER_OUTPUTS
);
    // ------------------------------------------------------------------
    // Defaults
    // ------------------------------------------------------------------
    // Pins pass a synchroniser, so each pin check waits a few stable cycles first.
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    ack_fixed_a: assert property (PREADY == 1'h1)
        else $error("ready dropped");
    unmapped_err_a: assert property (PSEL && PENABLE |-> PSLVERR == (PADDR != 8'h00 && PADDR != 8'h04))
        else $error("error response wrong");
    ctrl_readback_a: assert property (PSEL && PENABLE && PWRITE && PADDR == 8'h00 ##2
        PSEL && !PENABLE && !PWRITE && PADDR == 8'h00 |=> PRDATA == {31'h0, $past(PWDATA[0], 3)})
        else $error("control readback wrong");

    // ------------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------------
    blank_bottom_a: assert property ((!OUTPUT_BLANK_N) [*6] |=> DRIVER_OUTPUTS == 320'h0)
        else $error("blank not at bottom level");
    port_a_role_a: assert property (($stable(SHIFT_DIR_SELECT) && $stable(SEGMENT_MODE_SELECT)) [*8]
        |=> CASCADE_PORT_A_OE_N == $past(SHIFT_DIR_SELECT))
        else $error("port a direction wrong");
    port_b_role_a: assert property (($stable(SHIFT_DIR_SELECT) && $stable(SEGMENT_MODE_SELECT)) [*8]
        |=> CASCADE_PORT_B_OE_N == !$past(SHIFT_DIR_SELECT))
        else $error("port b direction wrong");
    casc_pull_a: assert property ((!SEGMENT_MODE_SELECT && $stable(SHIFT_DIR_SELECT)) [*8]
        |=> CASCADE_PORT_A_PULLDOWN == $past(SHIFT_DIR_SELECT)
        && CASCADE_PORT_B_PULLDOWN == !$past(SHIFT_DIR_SELECT))
        else $error("cascade pull wrong");
    dual_pull_a: assert property ((!SEGMENT_MODE_SELECT && $stable(WIDTH_OR_DUAL_SELECT)) [*8]
        |=> DUAL_CHAIN_PULLDOWN == $past(WIDTH_OR_DUAL_SELECT))
        else $error("dual pull wrong");
    pixel_pull_a: assert property ((!SEGMENT_MODE_SELECT) [*8] |=> PIXEL_CLOCK_PULLDOWN)
        else $error("pixel clock pull off");
endmodule

bind lcdsc_core lcdsc_core_assertions lcdsc_core_assertions_i
(
    .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .WIDTH_OR_DUAL_SELECT(WIDTH_OR_DUAL_SELECT), .SHIFT_DIR_SELECT(SHIFT_DIR_SELECT),
    .SEGMENT_MODE_SELECT(SEGMENT_MODE_SELECT), .OUTPUT_BLANK_N(OUTPUT_BLANK_N),
    .CASCADE_PORT_A_OE_N(CASCADE_PORT_A_OE_N), .CASCADE_PORT_B_OE_N(CASCADE_PORT_B_OE_N),
    .CASCADE_PORT_A_PULLDOWN(CASCADE_PORT_A_PULLDOWN),
    .CASCADE_PORT_B_PULLDOWN(CASCADE_PORT_B_PULLDOWN),
    .DUAL_CHAIN_PULLDOWN(DUAL_CHAIN_PULLDOWN), .PIXEL_CLOCK_PULLDOWN(PIXEL_CLOCK_PULLDOWN),
    .DRIVER_OUTPUTS(DRIVER_OUTPUTS)
);

// ===== test/lcdsc_ctrl_model.sv
// Timing controller and upstream neighbour model for the driver core.
`timescale 1ns/1ps
module lcdsc_ctrl_model
(
    // Clocks toward the driver.
    output logic pix_clk,
    output logic line_pulse,
    // Data and upstream cascade level.
    output logic [7:0] data,
    output logic casc_up
);
    // Half period of the link clock; edges sit 13 ns off the system clock.
    localparam time HALF = 160;

    // Pins idle with both clocks still.
    initial
    begin
        pix_clk = 1'h0;
        line_pulse = 1'h0;
        data = 8'h00;
        casc_up = 1'h1;
    end

    // One line pulse; every task lasts a whole number of system clocks.
    task automatic pulse;
        #13;
        line_pulse = 1'h1;
        #HALF line_pulse = 1'h0;
        #(HALF - 13);
    endtask

    // One line of words plus one extra clock that the driver must refuse.
    task automatic frame(input bit wide, input bit [7:0] key);
        int n;
        logic [7:0] w;
        n = wide ? 20 : 40;
        #13;
        casc_up = 1'h0;
        #HALF;
        for (int k = 0; k <= n; k++)
        begin
            // Data changes on the rise so it holds well past the fall.
            pix_clk = 1'h1;
            w = key ^ (8'h1D * (wide ? k : k / 2));
            data = wide ? w : {4'h0, k[0] ? w[3:0] : w[7:4]};
            if (k == n)
                data = ~data;
            casc_up = (k == 0) ? 1'h0 : 1'h1;
            #HALF pix_clk = 1'h0;
            #HALF;
        end
        data = ~data;
        #(HALF - 13);
    endtask

    // One common-mode shift; the pixel clock stays low and low data bits are tied.
    task automatic shift(input bit s, input bit d7);
        casc_up = s;
        data = {d7, 7'h00};
        pulse();
        casc_up = 1'h0;
    endtask
endmodule

// ===== test/tb.sv
// Self-checking bench for the driver core.
`timescale 1ns/1ps
`include "lcdsc_map.vh"
module tb;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic clock, rst_n, psel, penable, pwrite, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, q;
    logic width, dir, seg, blank_n, fr;
    logic [159:0] bits;
    wire [31:0] prdata;
    wire pready, pslverr, pix, lpulse, up, a_in, b_in, a_out, a_oe_n, b_out, b_oe_n;
    wire [7:0] data;
    wire [319:0] drv;
    int failures, checked, cycles, low_cnt;

    // A released cascade pin takes the upstream level in its input role.
    assign a_in = !a_oe_n ? a_out : (dir ? up : 1'h1);
    assign b_in = !b_oe_n ? b_out : (dir ? 1'h1 : up);

    lcdsc_core lcdsc_core_i
    (
        .CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .PIXEL_SHIFT_CLOCK(pix), .LINE_LATCH_PULSE(lpulse), .WIDTH_OR_DUAL_SELECT(width),
        .SHIFT_DIR_SELECT(dir), .SEGMENT_MODE_SELECT(seg), .OUTPUT_BLANK_N(blank_n),
        .FRAME_POLARITY(fr), .DISPLAY_DATA_IN(data), .CASCADE_PORT_A_IN(a_in),
        .CASCADE_PORT_A_OUT(a_out), .CASCADE_PORT_A_OE_N(a_oe_n), .CASCADE_PORT_B_IN(b_in),
        .CASCADE_PORT_B_OUT(b_out), .CASCADE_PORT_B_OE_N(b_oe_n),
        .CASCADE_PORT_A_PULLDOWN(), .CASCADE_PORT_B_PULLDOWN(), .DUAL_CHAIN_PULLDOWN(),
        .PIXEL_CLOCK_PULLDOWN(), .DRIVER_OUTPUTS(drv)
    );
    lcdsc_ctrl_model lcdsc_ctrl_model_i (.pix_clk(pix), .line_pulse(lpulse), .data(data),
        .casc_up(up));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Level per output from mode, polarity and bit; two bits per output.
    function automatic [319:0] lv(input bit s, input bit f, input [159:0] b);
        lv = 320'h0;
        for (int k = 0; k < 160; k++)
            lv[2*k +: 2] = (s ^ f) ? (b[k] ? 2'h0 : 2'h1) : (b[k] ? 2'h3 : 2'h2);
    endfunction

    // Latch image of a line of twenty words for the given fill direction.
    function automatic [159:0] seg_bits(input bit d, input [7:0] key);
        logic [7:0] w;
        seg_bits = 160'h0;
        for (int n = 0; n < 20; n++)
        begin
            w = key ^ (8'h1D * n);
            for (int i = 0; i < 8; i++)
                seg_bits[d ? 8*n+7-i : 152-8*n+i] = w[i];
        end
    endfunction

    task chk(input string n, input [319:0] x, input [319:0] g);
        checked++;
        if (g !== x)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask

    // One bus transfer: setup, then access until ready is seen.
    task apb(input bit w, input [7:0] a, input [31:0] d);
        @(posedge clock);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        @(posedge clock);
        while (pready !== 1'h1)
            @(posedge clock);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task settle;
        repeat (8) @(posedge clock);
    endtask

    // Arm, capture a line with a spare clock, then latch it.
    task line(input bit wide, input [7:0] key);
        low_cnt = 0;
        lcdsc_ctrl_model_i.pulse();
        lcdsc_ctrl_model_i.frame(wide, key);
        chk("cascade pulse", 1'h1, low_cnt >= 6 && low_cnt <= 9);
        chk("cascade idle", 1'h1, dir ? b_out : a_out);
        lcdsc_ctrl_model_i.pulse();
        settle;
    endtask

    // ------------------------------------------------------------------
    // Clock, timeout and cascade monitor
    // ------------------------------------------------------------------
    initial
    begin
        clock = 1'h0;
        forever #20 clock = ~clock;
    end

    // The run needs about 3640 cycles; the ceiling leaves ample margin.
    always @(posedge clock)
    begin
        cycles++;
        if ((!a_oe_n && !a_out) || (!b_oe_n && !b_out))
            low_cnt++;
        if (cycles == 20000)
        begin
            failures++;
            end_of_test;
        end
    end

    task end_of_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {width, dir, seg, blank_n, fr} = 5'h16;
        repeat (3) @(posedge clock);
        rst_n <= 1'h1;
        settle;
        bits = seg_bits(0, 8'h5A);
        line(1, 8'h5A);
        chk("seg fr low", lv(1, 0, bits), drv);
        fr <= 1'h1;
        settle;
        chk("seg fr high", lv(1, 1, bits), drv);
        width <= 1'h0;
        dir <= 1'h1;
        settle;
        bits = seg_bits(1, 8'hC3);
        line(0, 8'hC3);
        chk("seg nibble", lv(1, 1, bits), drv);
        apb(1, `LCDSC_ADDR_CTRL, 32'h1);
        settle;
        chk("soft blank", 320'h0, drv);
        apb(0, `LCDSC_ADDR_CTRL, 32'h0);
        chk("ctrl read", 32'h1, q);
        apb(1, `LCDSC_ADDR_CTRL, 32'h0);
        apb(0, `LCDSC_ADDR_CTRL, 32'h0);
        chk("ctrl clear", 32'h0, q);
        apb(0, 8'h08, 32'h0);
        chk("unmapped", {1'h1, 32'h0}, {e, q});
        apb(0, `LCDSC_ADDR_STATUS, 32'h0);
        chk("seg status", 1'h1, q[`LCDSC_ST_SEGMENT]);
        blank_n <= 1'h0;
        bits = seg_bits(1, 8'h96);
        line(0, 8'h96);
        chk("blanked", 320'h0, drv);
        blank_n <= 1'h1;
        settle;
        chk("deselect", lv(1, 1, 160'h0), drv);
        lcdsc_ctrl_model_i.pulse();
        settle;
        chk("after blank", lv(1, 1, bits), drv);
        seg <= 1'h0;
        dir <= 1'h0;
        fr <= 1'h0;
        settle;
        repeat (160) lcdsc_ctrl_model_i.shift(0, 0);
        lcdsc_ctrl_model_i.shift(1, 0);
        settle;
        chk("chain entry", lv(0, 0, {1'h1, 159'h0}), drv);
        repeat (159) lcdsc_ctrl_model_i.shift(0, 0);
        settle;
        chk("chain end", lv(0, 0, 160'h1), drv);
        chk("chain out", 2'h2, {a_out, a_oe_n});
        width <= 1'h1;
        settle;
        lcdsc_ctrl_model_i.shift(0, 1);
        settle;
        chk("dual entry", lv(0, 0, 160'h1 << 79), drv);
        dir <= 1'h1;
        settle;
        lcdsc_ctrl_model_i.shift(1, 0);
        lcdsc_ctrl_model_i.shift(0, 1);
        settle;
        chk("dual split", lv(0, 0, (160'h1 << 80) | 160'h2), drv);
        end_of_test;
    end
endmodule
